/* hw/crc_pkg.sv */
// Shared constants and types for the cold redundancy supervisor.
// Assumes a single 200 MHz clock; every time is turned into cycles here.
package crc_pkg;

  // Clock and time bases
  localparam longint unsigned CLK_PERIOD_PS = 64'd5000;
  localparam longint unsigned PS_PER_MS     = 64'd1000000000;
  localparam longint unsigned PS_PER_US     = 64'd1000000;

  // Blink half period, latch clear times, wake and alert limits
  localparam longint unsigned BLINK_HALF_MS  = 64'd500;
  localparam longint unsigned CLR_POWER_ON_REQUEST_N_MS    = 64'd1000;
  localparam longint unsigned CLR_INPUT_MS   = 64'd15000;
  localparam longint unsigned WAKE_MAX_US    = 64'd300;
  localparam longint unsigned ALERT_MAX_MS   = 64'd100;
  localparam logic [31:0] BLINK_HALF_CYC = 32'((BLINK_HALF_MS * PS_PER_MS) / CLK_PERIOD_PS);
  localparam logic [31:0] CLR_POWER_ON_REQUEST_N_CYC   = 32'((CLR_POWER_ON_REQUEST_N_MS * PS_PER_MS) / CLK_PERIOD_PS);
  localparam logic [31:0] CLR_INPUT_CYC  = 32'((CLR_INPUT_MS * PS_PER_MS) / CLK_PERIOD_PS);
  localparam logic [31:0] WAKE_MAX_CYC   = 32'((WAKE_MAX_US * PS_PER_US) / CLK_PERIOD_PS);
  localparam logic [31:0] ALERT_MAX_CYC  = 32'((ALERT_MAX_MS * PS_PER_MS) / CLK_PERIOD_PS);

  // Management command for the role byte and bus address base
  localparam logic [7:0] CMD_ROLE      = 8'hD0;
  localparam logic [7:0] ROLE_RESET    = 8'h00;
  localparam logic [7:0] MGMT_ADDR_BASE = 8'hB0;

  // Load thresholds in percent of full load
  localparam logic [7:0] LOAD_WAKE_PCT  = 8'h46;
  localparam logic [7:0] LOAD_SLEEP_PCT = 8'h28;

  // Temperature limits, degrees C; index 0 ambient, 1 secondary, 2 primary
  localparam int unsigned NUM_SENS = 3;
  localparam logic [2:0][7:0] TEMP_WARN = {8'h5A, 8'h60, 8'h3A};
  localparam logic [2:0][7:0] TEMP_CRIT = {8'h64, 8'h6A, 8'h44};

  typedef enum logic [7:0] {
    ROLE_NORMAL = 8'h00,
    ROLE_MASTER = 8'h01,
    ROLE_SLAVE  = 8'h02
  } crc_role_t;

  typedef enum logic [1:0] {
    PS_OFF  = 2'b00,
    PS_ON   = 2'b01,
    PS_COLD = 2'b10,
    PS_TRIP = 2'b11
  } crc_pwr_t;

  // Latching protection events
  typedef struct packed {
    logic out_ocp;
    logic out_ovp;
    logic out_uvp;
    logic fan_fail;
  } crc_prot_t;

  // Warnings where operation continues
  typedef struct packed {
    logic high_power;
    logic high_current;
    logic slow_fan;
  } crc_warn_t;

  typedef struct packed {
    logic green;
    logic amber;
  } crc_led_t;

endpackage : crc_pkg

/* hw/crc_temp_mon.sv */
// Temperature comparators for ambient and the two hot spots.
// Assumes sensor readings are whole degrees, synchronous to CLK.
`timescale 1ns/1ps
module crc_temp_mon (
  input  wire logic                 clk,      // System clock
  input  wire logic                 nrst,     // Async reset, low
  input  wire logic [2:0][7:0]      temp,     // Sensor readings
  output logic                      warn,     // Any sensor at warning
  output logic                      crit,     // Any sensor at critical
  output logic                      otp       // Main output held off
);
  logic [2:0] w_hit;
  logic [2:0] c_hit;
  logic       next_otp;

  genvar i;
  generate
    for (i = 0; i < crc_pkg::NUM_SENS; i++) begin : g_sens
      assign w_hit[i] = temp[i] >= crc_pkg::TEMP_WARN[i];
      assign c_hit[i] = temp[i] >= crc_pkg::TEMP_CRIT[i];
    end
  endgenerate

  // Recover only once every sensor is back below warning
  assign next_otp = (|c_hit) | (otp & (|w_hit));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warn <= 1'b0;
      crit <= 1'b0;
      otp  <= 1'b0;
    end else begin
      warn <= |w_hit;
      crit <= |c_hit;
      otp  <= next_otp;
    end
  end
endmodule : crc_temp_mon

/* hw/crc_blink.sv */
// Free running 1 Hz blink phase for the status LED.
// Assumes one clock; half period given in cycles.
`timescale 1ns/1ps
module crc_blink #(
  parameter logic [31:0] HALF_CYC = crc_pkg::BLINK_HALF_CYC
) (
  input  wire logic clk,    // System clock
  input  wire logic nrst,   // Async reset, low
  output logic      phase   // High during the lit half
);
  logic [31:0] cnt;
  logic        wrap;

  assign wrap = cnt == HALF_CYC - 32'h0000_0001;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt   <= 32'h0000_0000;
      phase <= 1'b0;
    end else begin
      cnt   <= wrap ? 32'h0000_0000 : cnt + 32'h0000_0001;
      phase <= wrap ? ~phase : phase;
    end
  end
endmodule : crc_blink

/* hw/crc_supervisor.sv */
// Cold redundancy supervisor: role byte, shared standby bus, power state,
// latch clearing, fan run-on and LED coding.
// Assumes all inputs synchronous to CLK; pad logic resolves the bus wire.
//
// Notes on behaviour
// - Any fault or low output pulls bus low; a slave with OUTPUT_GOOD low and no fault releases it
// - Standby module wakes when bus asserted
// - No high driver keeps every module on
// - Start in normal role, code 00h
// - Role command D0h, values 00h/01h/02h
// - Normal role drives bus actively low
// - Fault resets role; host rewrites it
// - Master drives low on fault or regulation loss
// - Master drives low above 70% load
// - Master drives high below 40% load
// - Slave role samples bus as input
// - Slave seeing high may enter standby
// - Slave seeing low powers on at once
// - Slave with any fault drives low
// - Standby wakes within 300 us
// - Green steady, off, or green blink
// - Amber steady on critical or lost input; LED is off instead when input is lost and PARALLEL_POWERED is low
// - Amber blink on continuing warnings
// - Temperature warning and critical within 100 ms
// - Over-temperature off, auto recover, aux stays
// - Input UV/OV off, auto restart, no latch
// - Fan runs on until components cool
// - Bus address from two select pins
// - Latch cleared by 1 s request off or 15 s
`timescale 1ns/1ps
module crc_supervisor #(
  parameter logic [31:0] BLINK_HALF = crc_pkg::BLINK_HALF_CYC,
  parameter logic [31:0] CLR_POWER_ON_REQUEST_N   = crc_pkg::CLR_POWER_ON_REQUEST_N_CYC,
  parameter logic [31:0] CLR_INPUT  = crc_pkg::CLR_INPUT_CYC
) (
  input  wire logic               CLK,                   // 200 MHz clock
  input  wire logic               NRST,                  // Async reset, low
  input  wire logic               CMD_WR,                // Management write strobe
  input  wire logic [7:0]         CMD_CODE,              // Management command code
  input  wire logic [7:0]         CMD_WDATA,             // Management write byte
  output logic [7:0]              CMD_RDATA,             // Management read byte
  input  wire logic               ADDRESS_SELECT_BIT0,   // Address strap bit 0
  input  wire logic               ADDRESS_SELECT_BIT1,   // Address strap bit 1
  output logic [7:0]              MGMT_ADDR,             // Resolved bus address
  input  wire logic               SHARED_STANDBY_BUS_IN, // Bus level seen
  output logic                    SHARED_STANDBY_BUS_OUT,// Bus level driven
  output logic                    SHARED_STANDBY_BUS_OE, // Bus driven when high
  input  wire logic               POWER_ON_REQUEST_N,    // Host on request, low
  input  wire logic               INPUT_PRESENT,         // Input power present
  input  wire logic               UNDER_VOLTAGE_TRIP,    // Input below trip
  input  wire logic               OVER_VOLTAGE_TRIP,     // Input above trip
  input  wire logic               PARALLEL_POWERED,      // A peer still has input
  input  wire logic               OUTPUT_GOOD,           // Main output in regulation
  input  wire logic [7:0]         LOAD_PCT,              // Load, percent of full
  input  wire crc_pkg::crc_prot_t PROT,                  // Latching protections
  input  wire crc_pkg::crc_warn_t WARN,                  // Continuing warnings
  input  wire logic [2:0][7:0]    TEMP,                  // Temperatures, deg C
  input  wire logic               COMPONENTS_COOL,       // Fan may stop
  output logic                    MAIN_ON,               // Main output enable
  output logic                    LOW_POWER_STANDBY_STATE, // Cold standby
  output logic                    FAN_ON,                // Fan control enable
  output logic                    ALERT_N,               // Alert line, low
  output crc_pkg::crc_led_t       LED                    // Front LED drive
);

  crc_pkg::crc_role_t role;
  crc_pkg::crc_pwr_t  st;
  crc_pkg::crc_pwr_t  next_st;
  logic        master_high;
  logic        next_master_high;
  logic [31:0] power_on_request_n_cnt;
  logic [31:0] input_cnt;
  logic        t_warn;
  logic        t_crit;
  logic        otp;
  logic        blink;

  crc_temp_mon u_temp (
    .clk  (CLK),
    .nrst (NRST),
    .temp (TEMP),
    .warn (t_warn),
    .crit (t_crit),
    .otp  (otp)
  );

  crc_blink #(.HALF_CYC(BLINK_HALF)) u_blink (
    .clk   (CLK),
    .nrst  (NRST),
    .phase (blink)
  );

  // Fault sources
  wire prot_event  = |PROT;
  wire input_fault = UNDER_VOLTAGE_TRIP | OVER_VOLTAGE_TRIP | ~INPUT_PRESENT;
  wire any_fault   = prot_event | input_fault | otp | (st == crc_pkg::PS_TRIP);
  wire out_of_reg  = input_fault | ((st == crc_pkg::PS_ON) & ~OUTPUT_GOOD);
  wire any_warn    = t_warn | (|WARN);

  // Role command decode
  wire role_hit  = CMD_CODE == crc_pkg::CMD_ROLE;
  wire role_ok   = CMD_WDATA == crc_pkg::ROLE_NORMAL || CMD_WDATA == crc_pkg::ROLE_MASTER ||
                   CMD_WDATA == crc_pkg::ROLE_SLAVE;
  wire role_wr   = CMD_WR & role_hit & role_ok;
  wire [7:0] next_rdata = role_hit ? role : 8'h00;
  // Fault wins over a write in the same cycle
  wire crc_pkg::crc_role_t next_role = any_fault ? crc_pkg::ROLE_NORMAL :
                                       role_wr ? crc_pkg::crc_role_t'(CMD_WDATA) : role;

  // Address from straps: bit 0 adds 2 and bit 1 adds 4 to the base
  wire [7:0] next_addr = crc_pkg::MGMT_ADDR_BASE |
                         {5'h00, ADDRESS_SELECT_BIT1, ADDRESS_SELECT_BIT0, 1'b0};

  // Master level with hysteresis band
  wire load_hi = LOAD_PCT > crc_pkg::LOAD_WAKE_PCT;
  wire load_lo = LOAD_PCT < crc_pkg::LOAD_SLEEP_PCT;
  assign next_master_high = (any_fault | out_of_reg | load_hi) ? 1'b0 :
                            load_lo ? 1'b1 :
                            master_high;

  // Bus drive: only a healthy slave releases the pin
  wire is_master = role == crc_pkg::ROLE_MASTER;
  wire is_slave  = role == crc_pkg::ROLE_SLAVE;
  wire next_oe   = ~is_slave | any_fault;
  wire next_out  = is_master & ~any_fault & next_master_high;

  // Standby needs a slave role and a peer driving the bus high
  wire stby_ok   = is_slave & SHARED_STANDBY_BUS_IN & ~any_fault;
  wire enable_ok = ~POWER_ON_REQUEST_N & ~input_fault & ~otp;

  // Latch clear timers
  wire power_on_request_n_clear  = power_on_request_n_cnt  >= CLR_POWER_ON_REQUEST_N;
  wire input_clear = input_cnt >= CLR_INPUT;
  wire [31:0] next_power_on_request_n_cnt  = ~POWER_ON_REQUEST_N ? 32'h0000_0000 :
                               power_on_request_n_clear ? power_on_request_n_cnt : power_on_request_n_cnt + 32'h0000_0001;
  wire [31:0] next_input_cnt = INPUT_PRESENT ? 32'h0000_0000 :
                               input_clear ? input_cnt : input_cnt + 32'h0000_0001;

  always_comb begin
    next_st = st;
    unique case (st)
      crc_pkg::PS_OFF: begin
        if (prot_event) begin
          next_st = crc_pkg::PS_TRIP;
        end else if (enable_ok) begin
          next_st = stby_ok ? crc_pkg::PS_COLD : crc_pkg::PS_ON;
        end
      end
      crc_pkg::PS_ON: begin
        if (prot_event) begin
          next_st = crc_pkg::PS_TRIP;
        end else if (!enable_ok) begin
          next_st = crc_pkg::PS_OFF;
        end else if (stby_ok) begin
          next_st = crc_pkg::PS_COLD;
        end
      end
      crc_pkg::PS_COLD: begin
        if (prot_event) begin
          next_st = crc_pkg::PS_TRIP;
        end else if (!enable_ok) begin
          next_st = crc_pkg::PS_OFF;
        end else if (!stby_ok) begin
          next_st = crc_pkg::PS_ON;
        end
      end
      crc_pkg::PS_TRIP: begin
        if (power_on_request_n_clear || input_clear) begin
          next_st = crc_pkg::PS_OFF;
        end
      end
    endcase
  end

  // LED coding, most severe first
  wire no_input   = ~INPUT_PRESENT;
  wire critical   = (st == crc_pkg::PS_TRIP) | t_crit;
  wire main_good  = (next_st == crc_pkg::PS_ON) & OUTPUT_GOOD;
  wire crc_pkg::crc_led_t next_led =
    (no_input & ~PARALLEL_POWERED)  ? crc_pkg::crc_led_t'{green: 1'b0,  amber: 1'b0}  :
    (no_input | critical)           ? crc_pkg::crc_led_t'{green: 1'b0,  amber: 1'b1}  :
    any_warn                        ? crc_pkg::crc_led_t'{green: 1'b0,  amber: blink} :
    main_good                       ? crc_pkg::crc_led_t'{green: 1'b1,  amber: 1'b0}  :
                                      crc_pkg::crc_led_t'{green: blink, amber: 1'b0};

  // Fan keeps running after shutdown until told components are cool
  wire next_fan = (next_st == crc_pkg::PS_ON) | (FAN_ON & ~COMPONENTS_COOL);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      role        <= crc_pkg::ROLE_NORMAL;
      st          <= crc_pkg::PS_OFF;
      master_high <= 1'b0;
      power_on_request_n_cnt    <= 32'h0000_0000;
      input_cnt   <= 32'h0000_0000;
    end else begin
      role        <= next_role;
      st          <= next_st;
      master_high <= next_master_high;
      power_on_request_n_cnt    <= next_power_on_request_n_cnt;
      input_cnt   <= next_input_cnt;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CMD_RDATA               <= 8'h00;
      MGMT_ADDR               <= crc_pkg::MGMT_ADDR_BASE;
      SHARED_STANDBY_BUS_OUT  <= 1'b0;
      SHARED_STANDBY_BUS_OE   <= 1'b1;
      MAIN_ON                 <= 1'b0;
      LOW_POWER_STANDBY_STATE <= 1'b0;
      FAN_ON                  <= 1'b0;
      ALERT_N                 <= 1'b1;
      LED                     <= '{green: 1'b0, amber: 1'b0};
    end else begin
      CMD_RDATA               <= next_rdata;
      MGMT_ADDR               <= next_addr;
      SHARED_STANDBY_BUS_OUT  <= next_out;
      SHARED_STANDBY_BUS_OE   <= next_oe;
      MAIN_ON                 <= next_st == crc_pkg::PS_ON;
      LOW_POWER_STANDBY_STATE <= next_st == crc_pkg::PS_COLD;
      FAN_ON                  <= next_fan;
      ALERT_N                 <= ~(t_warn | t_crit);
      LED                     <= next_led;
    end
  end

  // Checks

  property p_fault_low;
    @(posedge CLK) disable iff (!NRST)
      any_fault |=> SHARED_STANDBY_BUS_OE && !SHARED_STANDBY_BUS_OUT;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault did not pull bus low");

  property p_wake;
    @(posedge CLK) disable iff (!NRST)
      (st == crc_pkg::PS_COLD && !SHARED_STANDBY_BUS_IN && enable_ok && !prot_event)
      |=> MAIN_ON && !LOW_POWER_STANDBY_STATE;
  endproperty
  a_wake: assert property (p_wake) else $error("standby module did not wake");

  property p_stby_cause;
    @(posedge CLK) disable iff (!NRST)
      $rose(LOW_POWER_STANDBY_STATE) |-> $past(is_slave) && $past(SHARED_STANDBY_BUS_IN);
  endproperty
  a_stby_cause: assert property (p_stby_cause) else $error("standby without slave role and high bus");

  property p_role_legal;
    @(posedge CLK) disable iff (!NRST)
      role == crc_pkg::ROLE_NORMAL || role == crc_pkg::ROLE_MASTER || role == crc_pkg::ROLE_SLAVE;
  endproperty
  a_role_legal: assert property (p_role_legal) else $error("role byte holds an illegal code");

  property p_role_write;
    @(posedge CLK) disable iff (!NRST)
      (CMD_WR && role_hit && CMD_WDATA == crc_pkg::ROLE_SLAVE && !any_fault) |=> role == crc_pkg::ROLE_SLAVE;
  endproperty
  a_role_write: assert property (p_role_write) else $error("role write not taken");

  property p_normal_low;
    @(posedge CLK) disable iff (!NRST)
      role == crc_pkg::ROLE_NORMAL |=> SHARED_STANDBY_BUS_OE && !SHARED_STANDBY_BUS_OUT;
  endproperty
  a_normal_low: assert property (p_normal_low) else $error("normal role not driving low");

  property p_fault_role;
    @(posedge CLK) disable iff (!NRST)
      any_fault |=> role == crc_pkg::ROLE_NORMAL;
  endproperty
  a_fault_role: assert property (p_fault_role) else $error("fault did not reset role");

  property p_master_high;
    @(posedge CLK) disable iff (!NRST)
      (is_master && !any_fault && !out_of_reg && load_lo) |=> SHARED_STANDBY_BUS_OE && SHARED_STANDBY_BUS_OUT;
  endproperty
  a_master_high: assert property (p_master_high) else $error("master not driving high at light load");

  property p_master_wake;
    @(posedge CLK) disable iff (!NRST)
      (is_master && load_hi) |=> !SHARED_STANDBY_BUS_OUT;
  endproperty
  a_master_wake: assert property (p_master_wake) else $error("master not driving low at heavy load");

  property p_master_hold;
    @(posedge CLK) disable iff (!NRST)
      (is_master && !any_fault && !out_of_reg && !load_hi && !load_lo) |=> master_high == $past(master_high);
  endproperty
  a_master_hold: assert property (p_master_hold) else $error("master level moved inside band");

  property p_slave_input;
    @(posedge CLK) disable iff (!NRST)
      (is_slave && !any_fault) |=> !SHARED_STANDBY_BUS_OE;
  endproperty
  a_slave_input: assert property (p_slave_input) else $error("healthy slave drives the bus");

  property p_trip_hold;
    @(posedge CLK) disable iff (!NRST)
      (st == crc_pkg::PS_TRIP && !power_on_request_n_clear && !input_clear) |=> st == crc_pkg::PS_TRIP && !MAIN_ON;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("latched shutdown released early");

  property p_fan_runon;
    @(posedge CLK) disable iff (!NRST)
      ($fell(MAIN_ON) && !$past(COMPONENTS_COOL)) |-> FAN_ON;
  endproperty
  a_fan_runon: assert property (p_fan_runon) else $error("fan stopped before components cooled");

  property p_otp_off;
    @(posedge CLK) disable iff (!NRST)
      otp |=> !MAIN_ON;
  endproperty
  a_otp_off: assert property (p_otp_off) else $error("main output on during over-temperature");

  property p_alert;
    @(posedge CLK) disable iff (!NRST)
      t_crit && (INPUT_PRESENT || PARALLEL_POWERED) |=> !ALERT_N && LED.amber && !LED.green;
  endproperty
  a_alert: assert property (p_alert) else $error("critical temperature not signalled");

  property p_slave_fault;
    @(posedge CLK) disable iff (!NRST)
      (is_slave && any_fault) |=> SHARED_STANDBY_BUS_OE && !SHARED_STANDBY_BUS_OUT;
  endproperty
  a_slave_fault: assert property (p_slave_fault) else $error("faulty slave not pulling bus low");

  property p_prot_latch;
    @(posedge CLK) disable iff (!NRST)
      (prot_event && st != crc_pkg::PS_TRIP) |=> st == crc_pkg::PS_TRIP && !MAIN_ON;
  endproperty
  a_prot_latch: assert property (p_prot_latch) else $error("protection event did not latch off");

  property p_input_off;
    @(posedge CLK) disable iff (!NRST)
      (input_fault && !prot_event && st != crc_pkg::PS_TRIP) |=> st == crc_pkg::PS_OFF && !MAIN_ON;
  endproperty
  a_input_off: assert property (p_input_off) else $error("input fault did not turn main off unlatched");

  property p_lost_input;
    @(posedge CLK) disable iff (!NRST)
      (!INPUT_PRESENT && PARALLEL_POWERED) |=> LED.amber && !LED.green;
  endproperty
  a_lost_input: assert property (p_lost_input) else $error("lost input with powered peer not amber");

endmodule : crc_supervisor

/* sim/crc_peer_model.sv */
// Peer power modules on the shared standby bus, reduced to one bus driver.
// Assumes the testbench commands the peer drive level; resolves the wire.
`timescale 1ns/1ps
module crc_peer_model (
  input  wire logic       clk,     // System clock
  input  wire logic       dut_oe,  // Supervisor drives the bus
  input  wire logic       dut_out, // Supervisor drive level
  input  wire logic [1:0] mode,    // 0 released, 1 high, 2 low
  output logic            bus      // Resolved bus level
);
  logic [1:0] peer_drv;
  wire  low_drv = (dut_oe & ~dut_out) | (peer_drv == 2'h2);
  wire  hi_drv  = (dut_oe & dut_out) | (peer_drv == 2'h1);
  // Undriven bus reads low: with no high driver every module stays on
  assign bus = low_drv ? 1'h0 : hi_drv;
  // Peers change their drive on a clock edge, as the supervisor does
  always_ff @(posedge clk) begin
    peer_drv <= mode;
  end
endmodule : crc_peer_model

/* sim/tb_crc_supervisor.sv */
// Self-checking bench for the cold redundancy supervisor.
// Assumes short latch and blink counts; peer model drives the far bus side.
`timescale 1ns/1ps
module tb_crc_supervisor;
  logic              CLK = 1'h0, NRST = 1'h0, CMD_WR = 1'h0;
  logic [7:0]        CMD_CODE = 8'hD0, CMD_WDATA = 8'h00, LOAD_PCT = 8'h32;
  logic              ADDRESS_SELECT_BIT0 = 1'h0, ADDRESS_SELECT_BIT1 = 1'h0;
  logic              POWER_ON_REQUEST_N = 1'h1, INPUT_PRESENT = 1'h1;
  logic              UNDER_VOLTAGE_TRIP = 1'h0, OVER_VOLTAGE_TRIP = 1'h0;
  logic              PARALLEL_POWERED = 1'h0, OUTPUT_GOOD = 1'h1;
  logic              COMPONENTS_COOL = 1'h0;
  crc_pkg::crc_prot_t PROT = 4'h0;
  crc_pkg::crc_warn_t WARN = 3'h0;
  logic [2:0][7:0]   TEMP = 24'h19_1919;
  logic [1:0]        peer_mode = 2'h0;
  wire logic         SHARED_STANDBY_BUS_IN;
  logic [7:0]        CMD_RDATA, MGMT_ADDR;
  logic              SHARED_STANDBY_BUS_OUT, SHARED_STANDBY_BUS_OE;
  logic              MAIN_ON, LOW_POWER_STANDBY_STATE, FAN_ON, ALERT_N;
  crc_pkg::crc_led_t LED;
  int                n_mismatch = 0, check_count = 0;
  logic [7:0]        ld [6] = '{8'h32, 8'h27, 8'h28, 8'h46, 8'h47, 8'h28};
  logic              lo [6] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
  logic [7:0]        tw [3] = '{8'h3A, 8'h60, 8'h5A};
  logic [7:0]        tc [3] = '{8'h44, 8'h6A, 8'h64};

  always #2.5 CLK = ~CLK;

  crc_supervisor #(.BLINK_HALF(32'h0000_0004), .CLR_POWER_ON_REQUEST_N(32'h0000_0008), .CLR_INPUT(32'h0000_0010))
    crc_supervisor_i (.CLK, .NRST, .CMD_WR, .CMD_CODE, .CMD_WDATA, .CMD_RDATA, .ADDRESS_SELECT_BIT0,
      .ADDRESS_SELECT_BIT1, .MGMT_ADDR, .SHARED_STANDBY_BUS_IN, .SHARED_STANDBY_BUS_OUT,
      .SHARED_STANDBY_BUS_OE, .POWER_ON_REQUEST_N, .INPUT_PRESENT, .UNDER_VOLTAGE_TRIP,
      .OVER_VOLTAGE_TRIP, .PARALLEL_POWERED, .OUTPUT_GOOD, .LOAD_PCT, .PROT, .WARN, .TEMP,
      .COMPONENTS_COOL, .MAIN_ON, .LOW_POWER_STANDBY_STATE, .FAN_ON, .ALERT_N, .LED);

  crc_peer_model crc_peer_model_i (.clk(CLK), .dut_oe(SHARED_STANDBY_BUS_OE),
    .dut_out(SHARED_STANDBY_BUS_OUT), .mode(peer_mode), .bus(SHARED_STANDBY_BUS_IN));

  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    CMD_CODE  = code;
    CMD_WDATA = data;
    CMD_WR    = 1'h1;
    tick(1);
    CMD_WR    = 1'h0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    CMD_CODE = code;
    tick(2);
    chk(CMD_RDATA, exp);
  endtask : rd

  // One lit edge then four lit and four dark samples
  task automatic blink(input int b);
    logic [7:0] p;
    int n;
    n = 0;
    p = 8'h00;
    while (LED[b] !== 1'h0 && n < 20) begin
      tick(1);
      n++;
    end
    while (LED[b] !== 1'h1 && n < 40) begin
      tick(1);
      n++;
    end
    repeat (8) begin
      p = {p[6:0], LED[b]};
      tick(1);
    end
    chk(p, 8'hF0);
  endtask : blink

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    int n;
    tick(8);
    NRST = 1'h1;
    tick(2);
    rd(8'hD0, 8'h00);
    chk({SHARED_STANDBY_BUS_OE, SHARED_STANDBY_BUS_OUT}, 8'h02);
    for (int i = 0; i < 4; i++) begin
      {ADDRESS_SELECT_BIT1, ADDRESS_SELECT_BIT0} = 2'(i);
      tick(2);
      chk(MGMT_ADDR, 8'hB0 + 8'(2 * i));
    end
    POWER_ON_REQUEST_N = 1'h0;
    tick(3);
    chk({FAN_ON, MAIN_ON, LED}, 8'h0E);
    tick(4);
    chk(LED, 8'h02);
    wr(8'hD0, 8'h01);
    rd(8'hD0, 8'h01);
    wr(8'hD0, 8'h00);
    rd(8'hD0, 8'h00);
    wr(8'hD0, 8'h02);
    wr(8'hD0, 8'h03);
    rd(8'hD0, 8'h02);
    wr(8'h55, 8'h01);
    rd(8'h55, 8'h00);
    rd(8'hD0, 8'h02);
    wr(8'hD0, 8'h01);
    for (int i = 0; i < 6; i++) begin
      LOAD_PCT = ld[i];
      tick(3);
      chk({SHARED_STANDBY_BUS_OE, SHARED_STANDBY_BUS_OUT}, {7'h01, lo[i]});
    end
    LOAD_PCT = 8'h27;
    tick(3);
    chk(SHARED_STANDBY_BUS_OUT, 8'h01);
    OUTPUT_GOOD = 1'h0;
    tick(3);
    chk(SHARED_STANDBY_BUS_OUT, 8'h00);
    OUTPUT_GOOD = 1'h1;
    LOAD_PCT = 8'h32;
    wr(8'hD0, 8'h02);
    tick(3);
    chk(SHARED_STANDBY_BUS_OE, 8'h00);
    chk({LOW_POWER_STANDBY_STATE, MAIN_ON}, 8'h01);
    peer_mode = 2'h1;
    tick(4);
    chk({LOW_POWER_STANDBY_STATE, MAIN_ON, FAN_ON}, 8'h05);
    blink(1);
    COMPONENTS_COOL = 1'h1;
    tick(3);
    chk(FAN_ON, 8'h00);
    peer_mode = 2'h2;
    n = 0;
    while (MAIN_ON !== 1'h1 && n < 60000) begin
      tick(1);
      n++;
    end
    chk({LOW_POWER_STANDBY_STATE, MAIN_ON}, 8'h01);
    COMPONENTS_COOL = 1'h0;
    PROT = 4'h8;
    tick(1);
    PROT = 4'h0;
    tick(2);
    chk({SHARED_STANDBY_BUS_OE, SHARED_STANDBY_BUS_OUT, MAIN_ON, FAN_ON}, 8'h09);
    chk(LED, 8'h01);
    rd(8'hD0, 8'h00);
    POWER_ON_REQUEST_N = 1'h1;
    tick(4);
    POWER_ON_REQUEST_N = 1'h0;
    tick(3);
    chk(MAIN_ON, 8'h00);
    POWER_ON_REQUEST_N = 1'h1;
    tick(12);
    POWER_ON_REQUEST_N = 1'h0;
    tick(4);
    chk(MAIN_ON, 8'h01);
    PROT = 4'h1;
    tick(1);
    PROT = 4'h0;
    INPUT_PRESENT = 1'h0;
    PARALLEL_POWERED = 1'h1;
    tick(3);
    chk({SHARED_STANDBY_BUS_OE, SHARED_STANDBY_BUS_OUT, LED}, 8'h09);
    PARALLEL_POWERED = 1'h0;
    tick(3);
    chk(LED, 8'h00);
    tick(16);
    INPUT_PRESENT = 1'h1;
    tick(5);
    chk(MAIN_ON, 8'h01);
    for (int s = 0; s < 3; s++) begin
      TEMP[s] = tw[s] - 8'h01;
      tick(4);
      chk({ALERT_N, MAIN_ON}, 8'h03);
      TEMP[s] = tw[s];
      tick(4);
      chk({ALERT_N, MAIN_ON}, 8'h01);
      TEMP[s] = tc[s] - 8'h01;
      tick(4);
      chk({ALERT_N, MAIN_ON}, 8'h01);
      TEMP[s] = tc[s];
      tick(4);
      chk({ALERT_N, MAIN_ON, LED}, 8'h01);
      TEMP[s] = 8'h19;
      tick(5);
      chk({ALERT_N, MAIN_ON}, 8'h03);
    end
    for (int i = 0; i < 2; i++) begin
      {OVER_VOLTAGE_TRIP, UNDER_VOLTAGE_TRIP} = 2'(i + 1);
      tick(3);
      chk(MAIN_ON, 8'h00);
      {OVER_VOLTAGE_TRIP, UNDER_VOLTAGE_TRIP} = 2'h0;
      tick(5);
      chk(MAIN_ON, 8'h01);
    end
    for (int i = 0; i < 3; i++) begin
      WARN = 3'(1 << i);
      blink(0);
      chk(LED[1], 8'h00);
    end
    print_verdict();
  end
endmodule : tb_crc_supervisor
